// *** rtl/selfprog_pkg.sv ***
package selfprog_pkg;

  // Word addressing of the program flash
  localparam int COUNTER_TOP_BIT = 15;
  localparam int PAGE_INDEX_TOP_BIT = 6;
  localparam int POINTER_COUNTER_TOP_BIT = COUNTER_TOP_BIT + 1;
  localparam int POINTER_PAGE_INDEX_TOP_BIT = PAGE_INDEX_TOP_BIT + 1;
  localparam int PAGE_BITS = COUNTER_TOP_BIT - PAGE_INDEX_TOP_BIT;
  localparam int WORD_BITS = PAGE_INDEX_TOP_BIT + 1;
  localparam int PAGE_WORDS = 128;
  localparam int PAGE_SIZE_BYTES = PAGE_WORDS * 2;
  localparam int READABLE_PAGES = 480;
  localparam int BLOCKED_PAGES = 32;

  // Boot region start per size selection
  localparam logic [15:0] BOOT_START_512 = 16'hfe00;
  localparam logic [15:0] BOOT_START_1024 = 16'hfc00;
  localparam logic [15:0] BOOT_START_2048 = 16'hf800;
  localparam logic [15:0] BOOT_START_4096 = 16'hf000;
  localparam logic [15:0] READABLE_REGION_END = 16'hefff;
  localparam logic [15:0] BLOCKED_REGION_START = 16'hf000;
  localparam logic [15:0] BLOCKED_REGION_END = 16'hffff;

  // Bits of the device's self-programming control register
  localparam int SELFPROG_ENABLE_BIT = 0;
  localparam int PAGE_ERASE_BIT = 1;
  localparam int PAGE_WRITE_BIT = 2;
  localparam int APP_REGION_REENABLE_BIT = 4;
  localparam int APP_REGION_BUSY_FLAG = 6;

  // Store must follow the control write within this many cycles
  localparam int STORE_WINDOW_CYCLES = 4;

  // Own register map, byte addresses
  localparam logic [7:0] CMD_OFFSET = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] CONFIG_OFFSET = 8'h10;
  localparam logic [7:0] INFO_OFFSET = 8'h14;

  // Field positions in own registers
  localparam int ADDR_WORD_LSB = 16;
  localparam int ADDR_BYTE_BIT = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_APP_BUSY_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_DONE_BIT = 3;
  localparam int INFO_READABLE_BIT = 16;
  localparam logic [1:0] BOOT_SIZE_RESET = 2'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0]
  {
    OP_NONE = 3'h0,
    OP_ERASE = 3'h1,
    OP_FILL = 3'h2,
    OP_WRITE = 3'h3,
    OP_REENABLE = 3'h4,
    OP_LOAD = 3'h5
  } op_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_POLL = 3'b001,
    ST_EEWAIT = 3'b011,
    ST_CTRLWR = 3'b010,
    ST_STORE = 3'b110,
    ST_LOAD = 3'b100
  } state_t;

  // Everything the controller drives toward the device
  typedef struct packed {
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic store;
    logic load;
    logic irq_hold;
    logic [15:0] pointer;
    logic pointer_ext;
    logic [7:0] r0;
    logic [7:0] r1;
  } dev_drive_t;

  // Everything the device answers with
  typedef struct packed {
    logic [7:0] ctrl_rdata;
    logic eeprom_write_active_flag;
    logic load_valid;
    logic [7:0] load_data;
  } dev_sense_t;

endpackage : selfprog_pkg

// *** rtl/flash_addr_map.sv ***
`timescale 1ns/1ns
module flash_addr_map
  import selfprog_pkg::*;
(
  // Size and target
  input wire logic [1:0] boot_size_sel,
  input wire logic [PAGE_BITS-1:0] page,
  input wire logic [WORD_BITS-1:0] word,
  input wire logic byte_sel,
  input wire logic page_op,
  // Pointer image
  output logic [15:0] pointer,
  output logic pointer_ext,
  // Region facts
  output logic [15:0] boot_start,
  output logic in_readable_region
);

  logic [COUNTER_TOP_BIT:0] word_addr;
  logic [WORD_BITS-1:0] word_field;
  logic byte_field;
  logic [POINTER_COUNTER_TOP_BIT:0] full_pointer;
  logic boot_size_sel_hi;
  logic boot_size_sel_lo;

  assign boot_size_sel_hi = boot_size_sel[1];
  assign boot_size_sel_lo = boot_size_sel[0];
  assign boot_start = boot_size_sel_hi ?
    (boot_size_sel_lo ? BOOT_START_512 : BOOT_START_1024) :
    (boot_size_sel_lo ? BOOT_START_2048 : BOOT_START_4096);

  assign word_field = page_op ? '0 : word;
  assign byte_field = page_op ? 1'b0 : byte_sel;
  assign word_addr = {page, word};
  assign full_pointer = {page, word_field, byte_field};
  assign pointer = full_pointer[15:0];
  assign pointer_ext = full_pointer[POINTER_COUNTER_TOP_BIT];
  assign in_readable_region = word_addr <= READABLE_REGION_END;

endmodule : flash_addr_map

// *** rtl/selfprog_host.sv ***
// Operation
// - Buffer word select is pointer bits 7..1; zero during page write.
// - Pointer bit 0 zero for self-programming; byte select for loads. The code zeroes it only for erase and write; fill passes byte select.
// - Application region stays unreadable while its busy flag is set.
// - Poll enable bit clear before issuing a new command.
// - Wait for EEPROM write-active flag low before writing control register.
// - Hold interrupts, write control, store at once, then release.
// - Erase: set erase bit with enable; device erases pointer page.
// - Fill: data word in r1:r0, only enable set; stored at pointer.
// - Write: pointer at page start, write bit with enable commits buffer.
// - Re-enable bit with enable clears busy flag, reopens application region.
// - Page size in bytes is twice words; pointer steps by 2 per word.
// - Store must follow control write within four cycles or is dropped.
`timescale 1ns/1ns
module selfprog_host
  import selfprog_pkg::*;
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device side
  output dev_drive_t dev_drive,
  input wire dev_sense_t dev_sense
);

  state_t state;
  state_t next_state;
  op_t op;
  logic [PAGE_BITS-1:0] page;
  logic [WORD_BITS-1:0] word;
  logic byte_sel;
  logic [15:0] data_word;
  logic [7:0] load_result;
  logic [1:0] boot_size_sel;
  logic app_busy;
  logic refused;
  logic done;
  logic [2:0] store_gap;
  logic wr_pend;
  logic [7:0] wr_addr;

  // Bus decode
  wire bus_take = ce && hsel && hready && htrans == HTRANS_NONSEQ;
  wire take_write = bus_take && hwrite;
  wire take_read = bus_take && !hwrite;
  wire [7:0] bus_addr = haddr[7:0];
  wire wr_cmd = wr_pend && wr_addr == CMD_OFFSET;
  wire wr_addr_reg = wr_pend && wr_addr == ADDR_OFFSET;
  wire wr_data = wr_pend && wr_addr == DATA_OFFSET;
  wire wr_status = wr_pend && wr_addr == STATUS_OFFSET;
  wire wr_config = wr_pend && wr_addr == CONFIG_OFFSET;

  // Command acceptance
  wire op_t new_op = op_t'(hwdata[2:0]);
  wire new_op_legal = new_op inside {OP_ERASE, OP_FILL, OP_WRITE, OP_REENABLE, OP_LOAD};
  wire idle = state == ST_IDLE;
  wire page_op = op == OP_ERASE || op == OP_WRITE;
  wire [15:0] map_pointer;
  wire map_pointer_ext;
  wire [15:0] boot_start;
  wire in_readable_region;
  wire load_blocked = op == OP_LOAD && in_readable_region && app_busy;
  wire cmd_start = wr_cmd && idle && new_op_legal;
  wire cmd_refused = wr_cmd && !(idle && new_op_legal);

  // Sequencer events
  wire enter_ctrlwr = next_state == ST_CTRLWR;
  wire enter_store = next_state == ST_STORE;
  wire store_in_window = store_gap < 3'(STORE_WINDOW_CYCLES);
  wire issue_load = state == ST_POLL && next_state == ST_LOAD && !load_blocked;
  wire load_taken = state == ST_LOAD && dev_sense.load_valid && !load_blocked;
  wire load_refused = state == ST_LOAD && load_blocked;
  wire op_finishing = next_state == ST_IDLE && !idle;
  wire clr_refused = wr_status && hwdata[STAT_REFUSED_BIT];
  wire clr_done = wr_status && hwdata[STAT_DONE_BIT];
  wire addr_accept = wr_addr_reg && idle;
  wire data_accept = wr_data && idle;

  flash_addr_map u_map
  (
    .boot_size_sel(boot_size_sel),
    .page(page),
    .word(word),
    .byte_sel(byte_sel),
    .page_op(page_op),
    .pointer(map_pointer),
    .pointer_ext(map_pointer_ext),
    .boot_start(boot_start),
    .in_readable_region(in_readable_region)
  );

  // Device status bits
  wire dev_enable_busy = dev_sense.ctrl_rdata[SELFPROG_ENABLE_BIT];
  wire dev_app_busy = dev_sense.ctrl_rdata[APP_REGION_BUSY_FLAG];

  // Control value per operation
  logic [7:0] ctrl_value;
  always_comb
  begin
    ctrl_value = '0;
    ctrl_value[SELFPROG_ENABLE_BIT] = 1'b1;
    unique case (op)
      OP_ERASE: ctrl_value[PAGE_ERASE_BIT] = 1'b1;
      OP_WRITE: ctrl_value[PAGE_WRITE_BIT] = 1'b1;
      OP_REENABLE: ctrl_value[APP_REGION_REENABLE_BIT] = 1'b1;
      OP_NONE, OP_FILL, OP_LOAD: ;
      default: ctrl_value = '0;
    endcase
  end

  // Sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (cmd_start)
          next_state = ST_POLL;
      ST_POLL:
        if (!dev_enable_busy)
          next_state = (op == OP_LOAD) ? ST_LOAD : ST_EEWAIT;
      ST_EEWAIT:
        if (!dev_sense.eeprom_write_active_flag)
          next_state = ST_CTRLWR;
      ST_CTRLWR:
        next_state = ST_STORE;
      ST_STORE:
        next_state = ST_IDLE;
      ST_LOAD:
        if (dev_sense.load_valid || load_blocked)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= ST_IDLE;
    else if (ce)
      state <= next_state;
  end

  // Cycles since the control write; store lands inside the window
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      store_gap <= '1;
    else if (ce)
    begin
      if (enter_ctrlwr)
        store_gap <= '0;
      else if (store_gap != '1)
        store_gap <= store_gap + 3'h1;
    end
  end

  // Drive toward the device
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dev_drive <= '0;
    else if (ce)
    begin
      dev_drive.ctrl_wr <= enter_ctrlwr;
      dev_drive.ctrl_wdata <= ctrl_value;
      dev_drive.store <= enter_store && store_in_window;
      dev_drive.load <= issue_load;
      dev_drive.irq_hold <= next_state inside {ST_CTRLWR, ST_STORE};
      dev_drive.pointer <= map_pointer;
      dev_drive.pointer_ext <= map_pointer_ext;
      dev_drive.r0 <= data_word[7:0];
      dev_drive.r1 <= data_word[15:8];
    end
  end

  // Bus write capture for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end
    else if (ce)
    begin
      wr_pend <= take_write;
      wr_addr <= bus_addr;
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op <= OP_NONE;
      page <= '0;
      word <= '0;
      byte_sel <= 1'b0;
      data_word <= '0;
      boot_size_sel <= BOOT_SIZE_RESET;
    end
    else if (ce)
    begin
      if (cmd_start)
        op <= new_op;
      if (addr_accept)
      begin
        page <= hwdata[PAGE_BITS-1:0];
        word <= hwdata[ADDR_WORD_LSB +: WORD_BITS];
        byte_sel <= hwdata[ADDR_BYTE_BIT];
      end
      if (data_accept)
        data_word <= hwdata[15:0];
      if (wr_config)
        boot_size_sel <= hwdata[1:0];
    end
  end

  // Status flags; a hardware set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      app_busy <= 1'b0;
      refused <= 1'b0;
      done <= 1'b0;
      load_result <= '0;
    end
    else if (ce)
    begin
      app_busy <= dev_app_busy;
      refused <= cmd_refused || load_refused ||
        (refused && !clr_refused);
      done <= op_finishing ||
        (done && !clr_done);
      if (load_taken)
        load_result <= dev_sense.load_data;
    end
  end

  // Read data
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = '0;
    unique case (bus_addr)
      CMD_OFFSET: next_rdata[2:0] = op;
      ADDR_OFFSET:
      begin
        next_rdata[PAGE_BITS-1:0] = page;
        next_rdata[ADDR_WORD_LSB +: WORD_BITS] = word;
        next_rdata[ADDR_BYTE_BIT] = byte_sel;
      end
      DATA_OFFSET: next_rdata[7:0] = load_result;
      STATUS_OFFSET:
      begin
        next_rdata[STAT_BUSY_BIT] = !idle;
        next_rdata[STAT_APP_BUSY_BIT] = app_busy;
        next_rdata[STAT_REFUSED_BIT] = refused;
        next_rdata[STAT_DONE_BIT] = done;
      end
      CONFIG_OFFSET: next_rdata[1:0] = boot_size_sel;
      INFO_OFFSET:
      begin
        next_rdata[15:0] = boot_start;
        next_rdata[INFO_READABLE_BIT] = in_readable_region;
      end
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (ce && take_read)
      hrdata <= next_rdata;
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

endmodule : selfprog_host

// *** testbench/flash_dev_model.sv ***
`timescale 1ns/1ns
module flash_dev_model
  import selfprog_pkg::*;
(
  // Clock, reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench control
  input wire logic ee_busy,
  // Controller link
  input wire dev_drive_t drv,
  output dev_sense_t sns,
  // Observed state
  output logic [8:0] wr_page,
  output logic [15:0] buf_word
);
  logic [7:0] ctrl;
  logic [7:0] ld;
  logic [3:0] cnt;
  logic [2:0] age;
  logic lv;
  assign sns = {ctrl, ee_busy, lv, ld};
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ctrl <= 8'h00;
      ld <= 8'h00;
      cnt <= 4'h0;
      age <= 3'h7;
      lv <= 1'b0;
      wr_page <= 9'h000;
      buf_word <= 16'h0000;
    end
    else
    begin
      age <= drv.ctrl_wr ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
      lv <= drv.load;
      // Released data line toggles
      ld <= drv.load ? drv.pointer[7:0] + 8'(drv.pointer_ext) : ~ld;
      if (drv.ctrl_wr)
        ctrl <= drv.ctrl_wdata | (ctrl & 8'h40);
      else if (drv.store && age < 3'h4)
      begin
        cnt <= 4'h6;
        if (ctrl[1] || ctrl[2])
          ctrl[6] <= 1'b1;
        if (ctrl[4])
          ctrl[6] <= 1'b0;
        if (ctrl[2])
          wr_page <= {drv.pointer_ext, drv.pointer[15:8]};
        if (ctrl[4:1] == 4'h0)
          buf_word <= {drv.r1, drv.r0};
      end
      else if (cnt != 4'h0)
      begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1)
          ctrl[4:0] <= 5'h00;
      end
      else if (age == 3'h4)
        ctrl[4:0] <= 5'h00;
    end
endmodule : flash_dev_model

// *** testbench/selfprog_host_asserts.sv ***
`timescale 1ns/1ns
module selfprog_host_asserts
  import selfprog_pkg::*;
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Device side
  input wire dev_drive_t dev_drive,
  input wire dev_sense_t dev_sense
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic wr;
  logic st;
  assign wr = dev_drive.ctrl_wr;
  assign st = dev_drive.store;

  a_store_next: assert property (wr && ce |=> st)
    else $error("store missing after control write");
  a_store_cause: assert property (st |-> $past(wr))
    else $error("store without control write");
  a_irq_hold: assert property ((wr || st) |-> dev_drive.irq_hold)
    else $error("interrupts not held");
  a_ee_idle: assert property (wr |-> !$past(dev_sense.eeprom_write_active_flag))
    else $error("control write during eeprom write");
  a_poll_clear: assert property (wr |-> !dev_sense.ctrl_rdata[0])
    else $error("control write while enable busy");
  a_page_aligned: assert property (wr && |dev_drive.ctrl_wdata[2:1]
    |-> dev_drive.pointer[7:0] == 8'h00)
    else $error("page command pointer not aligned");
  a_enable_set: assert property (wr |-> dev_drive.ctrl_wdata[0])
    else $error("command without enable");
  a_load_guard: assert property (dev_drive.load |-> !dev_sense.ctrl_rdata[6]
    || (dev_drive.pointer_ext && dev_drive.pointer[15:13] == 3'h7))
    else $error("load from blocked region");
  a_single_pulse: assert property ((wr || dev_drive.load) |=> !(wr || dev_drive.load))
    else $error("pulse longer than one cycle");

  cover property (wr && dev_drive.ctrl_wdata == 8'h03);
  cover property (wr && dev_drive.ctrl_wdata == 8'h05);
  cover property (wr && dev_drive.ctrl_wdata == 8'h11);
  cover property (dev_drive.load);
endmodule : selfprog_host_asserts

bind selfprog_host selfprog_host_asserts i_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .dev_drive(dev_drive), .dev_sense(dev_sense));

// *** testbench/selfprog_host_test.sv ***
`timescale 1ns/1ns
module selfprog_host_test
  import selfprog_pkg::*;
;
  logic hclk, hresetn, ce, hsel, hwrite, ee_busy, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  dev_drive_t drv, last;
  dev_sense_t sns;
  logic [8:0] wr_page;
  logic [15:0] buf_word;
  logic [15:0] bstart [4] = '{16'hf000, 16'hf800, 16'hfc00, 16'hfe00};
  int n_mismatch, comparisons, n_wr, n, tn;

  selfprog_host i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .dev_drive(drv), .dev_sense(sns));
  flash_dev_model i_dev (.hclk(hclk), .hresetn(hresetn), .ee_busy(ee_busy), .drv(drv),
    .sns(sns), .wr_page(wr_page), .buf_word(buf_word));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk)
    if (drv.ctrl_wr === 1'b1)
    begin
      n_wr++;
      last = drv;
    end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic idle;
    for (int i = 0; i < 40; i++)
    begin
      bus(1'b0, STATUS_OFFSET, 32'h0);
      if (rd[STAT_BUSY_BIT] === 1'b0)
        break;
    end
    check(32'(rd[STAT_BUSY_BIT]), 32'h0);
  endtask : idle

  task automatic tend;
    tn++;
    $display("test %0d end", tn);
  endtask : tend

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  initial
  begin
    #200000;
    n_mismatch++;
    summarize;
  end

  initial
  begin
    {hresetn, hsel, hwrite, ee_busy, haddr, hwdata, htrans} = '0;
    ce = 1'b1;
    hsize = 3'h2;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    rdchk(CONFIG_OFFSET, 32'h0);
    rdchk(STATUS_OFFSET, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, CONFIG_OFFSET, 32'(s));
      rdchk(INFO_OFFSET, {15'h0, 1'b1, bstart[s]});
    end
    bus(1'b1, CONFIG_OFFSET, 32'h0);
    bus(1'b1, ADDR_OFFSET, 32'h007f_01df);
    rdchk(INFO_OFFSET, 32'h0001_f000);
    bus(1'b1, ADDR_OFFSET, 32'h0000_01e0);
    rdchk(INFO_OFFSET, 32'h0000_f000);
    tend;
    // Erase forces word field to zero
    bus(1'b1, ADDR_OFFSET, 32'h0005_01e3);
    bus(1'b1, CMD_OFFSET, 32'h1);
    idle;
    check(32'(last.ctrl_wdata), 32'h03);
    check(32'({last.pointer_ext, last.pointer}), 32'h1e300);
    rdchk(STATUS_OFFSET, 32'h0a);
    bus(1'b1, ADDR_OFFSET, 32'h0000_0010);
    bus(1'b1, CMD_OFFSET, 32'h5);
    idle;
    check(rd & 32'h6, 32'h6);
    bus(1'b1, STATUS_OFFSET, 32'hc);
    bus(1'b1, ADDR_OFFSET, 32'h0103_01f0);
    bus(1'b1, CMD_OFFSET, 32'h5);
    idle;
    rdchk(DATA_OFFSET, 32'h08);
    bus(1'b1, CMD_OFFSET, 32'h4);
    idle;
    check(32'(last.ctrl_wdata), 32'h11);
    rdchk(STATUS_OFFSET, 32'h08);
    tend;
    // Fill held back by eeprom write
    ee_busy <= 1'b1;
    bus(1'b1, ADDR_OFFSET, 32'h007f_0005);
    bus(1'b1, DATA_OFFSET, 32'h0000_beef);
    n = n_wr;
    bus(1'b1, CMD_OFFSET, 32'h2);
    repeat (10) @(posedge hclk);
    check(32'(n_wr), 32'(n));
    ee_busy <= 1'b0;
    idle;
    check(32'(last.ctrl_wdata), 32'h01);
    check(32'(last.pointer), 32'h05fe);
    check(32'(buf_word), 32'hbeef);
    bus(1'b1, ADDR_OFFSET, 32'h0000_0005);
    bus(1'b1, CMD_OFFSET, 32'h3);
    idle;
    check(32'(last.ctrl_wdata), 32'h05);
    check(32'(wr_page), 32'h005);
    tend;
    // Second command while first still busy
    bus(1'b1, CMD_OFFSET, 32'h1);
    bus(1'b1, CMD_OFFSET, 32'h1);
    idle;
    check(32'(rd[STAT_REFUSED_BIT]), 32'h1);
    tend;
    summarize;
  end
endmodule : selfprog_host_test
